// ### mc_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
module mc_clkgen (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [7:0] tuning_word,
  output logic            pitch_ref,
  output logic [3:0]      wave_timing
);
  // timing rom: {refresh, row_addr_sel, row_strobe, col_strobe}
  localparam logic [3:0] ROM [16] = '{
    4'h0, 4'h2, 4'h6, 4'h7, 4'h7, 4'h3, 4'h1, 4'h0,
    4'h8, 4'hA, 4'hE, 4'hE, 4'h6, 4'h2, 4'h0, 4'h0};

  logic       half_reg, half_next;
  logic [8:0] acc_reg, acc_next;
  logic       ref_reg, ref_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] tim_reg, tim_next;

  always_comb begin
    half_next = ~half_reg;
    acc_next  = acc_reg;
    ref_next  = ref_reg;
    cnt_next  = cnt_reg;
    tim_next  = tim_reg;
    if (half_reg) begin
      acc_next = {1'b0, acc_reg[7:0]} + {1'b0, tuning_word};
      ref_next = acc_next[8] ? ~ref_reg : ref_reg;
      cnt_next = cnt_reg + 4'h1;
      tim_next = ROM[cnt_reg];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      half_reg <= 1'b0;
      acc_reg  <= 9'h000;
      ref_reg  <= 1'b0;
      cnt_reg  <= 4'h0;
      tim_reg  <= 4'h0;
    end else begin
      half_reg <= half_next;
      acc_reg  <= acc_next;
      ref_reg  <= ref_next;
      cnt_reg  <= cnt_next;
      tim_reg  <= tim_next;
    end
  end

  assign pitch_ref   = ref_reg;
  assign wave_timing = tim_reg;

  a_half_rate: assert property (@(posedge clock) disable iff (!nrst)
    !half_reg |=> half_reg ##1 !half_reg)
    else $error("divided rate not symmetrical");
  a_rom_step: assert property (@(posedge clock) disable iff (!nrst)
    half_reg |=> wave_timing == ROM[$past(cnt_reg)])
    else $error("timing rom output not latched");
endmodule : mc_clkgen
`default_nettype wire

// ### mc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// converter on the far side: answers each start after a set delay
// ----------------------------------------------------------------
module mc_conv_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       conv_start,
  input  wire logic [7:0] answer_delay,
  input  wire logic [9:0] result,
  output logic            conversion_done_n,
  output logic [9:0]      converter_data
);
  logic       start_q;
  logic       busy;
  logic [7:0] wait_cnt;
  logic [2:0] ready_cnt;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      start_q   <= 1'b0;
      busy      <= 1'b0;
      wait_cnt  <= 8'h00;
      ready_cnt <= 3'd0;
    end else begin
      start_q <= conv_start;
      if (conv_start && !start_q) begin
        busy     <= 1'b1;
        wait_cnt <= answer_delay;
      end else if (busy && wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end else if (busy) begin
        busy      <= 1'b0;
        ready_cnt <= 3'd4;
      end
      if (ready_cnt != 3'd0) begin
        ready_cnt <= ready_cnt - 3'd1;
      end
    end
  end

  assign conversion_done_n = (ready_cnt == 3'd0);
  // data is only meaningful while ready is low
  assign converter_data = conversion_done_n ? ~result : result;
endmodule : mc_conv_model
`default_nettype wire

// ### mc_irq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mc_irq_if;
  logic       level_wr;
  logic [3:0] level_data;
  logic       int_n;
  logic       req;
  logic [3:0] vec_level;
  modport ctl (output level_wr, output level_data,
               input int_n, input req, input vec_level);
  modport pic (input level_wr, input level_data,
               output int_n, output req, output vec_level);
endinterface : mc_irq_if
`default_nettype wire

// ### mc_master.sv
`timescale 1ns/1ps
`default_nettype none
module mc_master #(
  parameter int unsigned HALT_TIMEOUT_CYC = mc_pkg::HALT_TIMEOUT_CYC
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       bus_strobe,
  input  wire logic       bus_read,
  input  wire logic       bus_cpu_one,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  output logic [7:0]      bus_rdata,
  output logic            card_select,
  output logic [7:0]      channel_card_select,
  output logic [7:0]      tuning_word,
  output logic            pitch_ref,
  output logic            wave_refresh,
  output logic            wave_row_addr_sel,
  output logic            wave_row_strobe,
  output logic            wave_col_strobe,
  input  wire logic       keyboard_serial_irq,
  input  wire logic       timer_irq,
  input  wire logic       ipc_irq,
  output logic            pic_int_n,
  output logic            cpu_one_irq_request,
  output logic [3:0]      irq_level_bus,
  input  wire logic       converter_mode,
  input  wire logic       sample_clock,
  input  wire logic       conversion_done_n,
  input  wire logic [9:0] converter_data,
  output logic            conv_start,
  output logic            sample_hold,
  output logic            cpu_hold_n,
  output logic [7:0]      atten_word,
  output logic [3:0]      lowpass_sel,
  output logic [3:0]      highpass_sel
);
  localparam int START_CYC = mc_pkg::START_PULSE_CYC;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  mask_reg, mask_next;
  logic [7:0]  tune_reg, tune_next;
  logic [7:0]  atten_reg, atten_next;
  logic [7:0]  filt_reg, filt_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        sel_reg, sel_next;
  logic [7:0]  channel_card_select_reg, channel_card_select_next;
  logic [9:0]  adc_reg, adc_next;
  logic        sclk_d_reg, done_d_reg;
  logic [7:0]  shot_reg, shot_next;
  logic [mc_pkg::TMO_W-1:0] tmo_reg, tmo_next;
  mc_pkg::mc_halt_t halt_reg, halt_next;

  logic in_win, in_chan, wr, multi, halt_clr, done_fall, sclk_rise, timeout;
  logic [3:0] wave_timing;

  mc_irq_if irq ();

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    in_win = bus_strobe &&
      bus_addr[15:mc_pkg::WIN_LSB] == mc_pkg::WIN_BASE[15:mc_pkg::WIN_LSB];
    in_chan   = in_win && !bus_addr[mc_pkg::CHAN_BIT];
    wr        = in_win && !bus_read;
    multi     = (mask_reg & (mask_reg - 8'h01)) != 8'h00;
    halt_clr  = in_win && bus_cpu_one && bus_addr == mc_pkg::HALT_ADDR;
    done_fall = done_d_reg && !conversion_done_n;
    sclk_rise = !sclk_d_reg && sample_clock;
    timeout   = halt_reg == mc_pkg::MC_HALTED &&
                tmo_reg == mc_pkg::TMO_W'(HALT_TIMEOUT_CYC - 1);
  end

  // ----------------------------------------------------------------
  // register file and selects
  // ----------------------------------------------------------------
  always_comb begin
    mask_next  = mask_reg;
    tune_next  = tune_reg;
    atten_next = atten_reg;
    filt_next  = filt_reg;
    rdata_next = rdata_reg;
    sel_next   = in_win;
    channel_card_select_next = 8'h00;
    irq.level_wr   = 1'b0;
    irq.level_data = bus_wdata[3:0];
    if (in_chan) begin
      if (!bus_read) begin
        channel_card_select_next = mask_reg;
      end else if (!multi) begin
        channel_card_select_next = mask_reg;
      end
    end
    if (wr) begin
      unique case (bus_addr)
        mc_pkg::MASK_ADDR:   mask_next  = bus_wdata;
        mc_pkg::TUNE_ADDR:   tune_next  = bus_wdata;
        mc_pkg::ATTEN_ADDR:  atten_next = bus_wdata;
        mc_pkg::FILTER_ADDR: filt_next  = bus_wdata;
        mc_pkg::PRIO_ADDR:   irq.level_wr = 1'b1;
        default:             ;
      endcase
    end
    if (in_win && bus_read) begin
      unique case (bus_addr)
        mc_pkg::MASK_ADDR:   rdata_next = mask_reg;
        mc_pkg::TUNE_ADDR:   rdata_next = tune_reg;
        mc_pkg::ADC_LO_ADDR: rdata_next = adc_reg[7:0];
        mc_pkg::ADC_HI_ADDR: rdata_next = {6'h00, adc_reg[9:8]};
        mc_pkg::HALT_ADDR:   rdata_next = {7'h00, done_d_reg};
        mc_pkg::ATTEN_ADDR:  rdata_next = atten_reg;
        mc_pkg::FILTER_ADDR: rdata_next = filt_reg;
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_reg  <= mc_pkg::MASK_RST;
      tune_reg  <= mc_pkg::TUNE_RST;
      atten_reg <= mc_pkg::ATTEN_RST;
      filt_reg  <= mc_pkg::FILTER_RST;
      rdata_reg <= 8'h00;
      sel_reg   <= 1'b0;
      channel_card_select_reg <= 8'h00;
    end else begin
      mask_reg  <= mask_next;
      tune_reg  <= tune_next;
      atten_reg <= atten_next;
      filt_reg  <= filt_next;
      rdata_reg <= rdata_next;
      sel_reg   <= sel_next;
      channel_card_select_reg <= channel_card_select_next;
    end
  end

  // ----------------------------------------------------------------
  // converter sequencing
  // ----------------------------------------------------------------
  always_comb begin
    shot_next = shot_reg;
    adc_next  = adc_reg;
    tmo_next  = tmo_reg;
    halt_next = halt_reg;
    if (sclk_rise && !converter_mode) begin
      shot_next = 8'(START_CYC);
    end else if (shot_reg != 8'h00) begin
      shot_next = shot_reg - 8'h01;
    end
    if (done_fall) begin
      adc_next = converter_data;
    end
    unique case (halt_reg)
      mc_pkg::MC_RUN: begin
        tmo_next = '0;
        if (halt_clr && !done_fall) begin
          halt_next = mc_pkg::MC_HALTED;
        end
      end
      mc_pkg::MC_HALTED: begin
        tmo_next = tmo_reg + 1'b1;
        if (done_fall || timeout) begin
          halt_next = mc_pkg::MC_RUN;
        end
      end
      default: halt_next = mc_pkg::MC_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shot_reg   <= 8'h00;
      adc_reg    <= 10'h000;
      tmo_reg    <= '0;
      halt_reg   <= mc_pkg::MC_RUN;
      sclk_d_reg <= 1'b0;
      done_d_reg <= 1'b1;
    end else begin
      shot_reg   <= shot_next;
      adc_reg    <= adc_next;
      tmo_reg    <= tmo_next;
      halt_reg   <= halt_next;
      sclk_d_reg <= sample_clock;
      done_d_reg <= conversion_done_n;
    end
  end

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  mc_clkgen u_clkgen (
    .clock       (clock),
    .nrst        (nrst),
    .tuning_word (tune_reg),
    .pitch_ref   (pitch_ref),
    .wave_timing (wave_timing)
  );

  mc_pic u_pic (
    .clock               (clock),
    .nrst                (nrst),
    .keyboard_serial_irq (keyboard_serial_irq),
    .timer_irq           (timer_irq),
    .ipc_irq             (ipc_irq),
    .irq                 (irq.pic)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_rdata           = rdata_reg;
  assign card_select         = sel_reg;
  assign channel_card_select = channel_card_select_reg;
  assign tuning_word         = tune_reg;
  assign wave_refresh        = wave_timing[3];
  assign wave_row_addr_sel   = wave_timing[2];
  assign wave_row_strobe     = wave_timing[1];
  assign wave_col_strobe     = wave_timing[0];
  assign pic_int_n           = irq.int_n;
  assign cpu_one_irq_request = irq.req;
  assign irq_level_bus       = irq.vec_level;
  assign conv_start          = shot_reg != 8'h00;
  assign sample_hold         = done_d_reg;
  assign cpu_hold_n          = halt_reg[0];
  assign atten_word          = atten_reg;
  assign lowpass_sel         = filt_reg[3:0];
  assign highpass_sel        = filt_reg[7:4];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_card_sel_latch: assert property (
    bus_strobe |=> card_select ==
      ($past(bus_addr) >= mc_pkg::WIN_BASE &&
       $past(bus_addr) <= mc_pkg::WIN_BASE + 16'h003F))
    else $error("card select not latched");
  a_upper_no_chan: assert property (
    in_win && bus_addr[mc_pkg::CHAN_BIT] |=> channel_card_select == 8'h00)
    else $error("channel select outside lower half");
  a_chan_write_mask: assert property (
    in_chan && !bus_read |=> channel_card_select == $past(mask_reg))
    else $error("write select differs from mask");
  a_multi_read_block: assert property (
    in_chan && bus_read && $countones(mask_reg) > 1 |=>
      channel_card_select == 8'h00)
    else $error("multi-channel read not blocked");
  a_tune_write: assert property (
    wr && bus_addr == mc_pkg::TUNE_ADDR |=> tuning_word == $past(bus_wdata))
    else $error("tuning word not updated");
  a_start_pulse: assert property (
    sclk_rise && !converter_mode |=> conv_start [*8])
    else $error("start pulse too short");
  a_halt_enter: assert property (
    cpu_hold_n && halt_clr && !done_fall |=> !cpu_hold_n)
    else $error("halt access did not hold cpu");
  a_done_release: assert property (
    !cpu_hold_n && done_fall |=> cpu_hold_n &&
      adc_reg == $past(converter_data))
    else $error("data ready did not release cpu");
  a_timeout_release: assert property (
    timeout |=> cpu_hold_n)
    else $error("halt timeout not honoured");
  a_filter_split: assert property (
    wr && bus_addr == mc_pkg::FILTER_ADDR |=>
      lowpass_sel == $past(bus_wdata[3:0]) &&
      highpass_sel == $past(bus_wdata[7:4]))
    else $error("filter nibbles wrong");
  a_atten_follow: assert property (
    wr && bus_addr == mc_pkg::ATTEN_ADDR |=> atten_word == $past(bus_wdata))
    else $error("attenuation word not updated");
  a_card_idle: assert property (
    !bus_strobe |=> !card_select)
    else $error("card select without an access");
  a_chan_idle: assert property (
    !in_chan |=> channel_card_select == 8'h00)
    else $error("channel select without channel access");
  a_read_single: assert property (
    in_chan && bus_read && $countones(mask_reg) < 2 |=>
      channel_card_select == $past(mask_reg))
    else $error("single-channel read not selected");
  a_halt_stays: assert property (
    !cpu_hold_n && !done_fall && !timeout |=> !cpu_hold_n)
    else $error("cpu released without cause");
  a_hold_gate: assert property (
    ##1 sample_hold == $past(conversion_done_n))
    else $error("sample hold does not follow data ready");
endmodule : mc_master
`default_nettype wire

// ### mc_pic.sv
`timescale 1ns/1ps
`default_nettype none
module mc_pic (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic keyboard_serial_irq,
  input  wire logic timer_irq,
  input  wire logic ipc_irq,
  mc_irq_if.pic     irq
);
  logic [3:0] cur_reg, cur_next;
  logic [3:0] vec_reg, vec_next;
  logic       int_n_reg, int_n_next;
  logic       req_reg, req_next;
  logic [3:0] best;
  logic       any;

  always_comb begin
    any  = keyboard_serial_irq | timer_irq | ipc_irq;
    best = keyboard_serial_irq ? mc_pkg::LVL_KBD :
           timer_irq           ? mc_pkg::LVL_TIMER :
           ipc_irq             ? mc_pkg::LVL_IPC : 4'h0;
  end

  always_comb begin
    cur_next   = irq.level_wr ? irq.level_data : cur_reg;
    int_n_next = ~(any && (best > cur_reg));
    vec_next   = int_n_next ? vec_reg : best;
    req_next   = ~int_n_reg | (req_reg & ~irq.level_wr);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur_reg   <= mc_pkg::PRIO_RST;
      vec_reg   <= 4'h0;
      int_n_reg <= 1'b1;
      req_reg   <= 1'b0;
    end else begin
      cur_reg   <= cur_next;
      vec_reg   <= vec_next;
      int_n_reg <= int_n_next;
      req_reg   <= req_next;
    end
  end

  assign irq.int_n     = int_n_reg;
  assign irq.req       = req_reg;
  assign irq.vec_level = vec_reg;

  a_irq_set: assert property (@(posedge clock) disable iff (!nrst)
    !int_n_reg |=> req_reg)
    else $error("interrupt did not set request latch");
  a_irq_clear: assert property (@(posedge clock) disable iff (!nrst)
    irq.level_wr && int_n_reg |=> !req_reg)
    else $error("level write did not clear request latch");
endmodule : mc_pic
`default_nettype wire

// ### mc_pkg.sv
`default_nettype none
package mc_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [15:0] WIN_BASE     = 16'hE000;
  localparam logic [15:0] MASK_ADDR    = 16'hE020;
  localparam logic [15:0] TUNE_ADDR    = 16'hE022;
  localparam logic [15:0] ADC_LO_ADDR  = 16'hE024;
  localparam logic [15:0] ADC_HI_ADDR  = 16'hE025;
  localparam logic [15:0] HALT_ADDR    = 16'hE026;
  localparam logic [15:0] ATTEN_ADDR   = 16'hE028;
  localparam logic [15:0] FILTER_ADDR  = 16'hE029;
  localparam logic [15:0] PRIO_ADDR    = 16'hE030;
  localparam int          WIN_LSB      = 6;
  localparam int          CHAN_BIT     = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [7:0]  TUNE_RST     = 8'h80;
  localparam logic [7:0]  ATTEN_RST    = 8'h00;
  localparam logic [7:0]  FILTER_RST   = 8'h00;
  localparam logic [3:0]  PRIO_RST     = 4'h0;

  // ----------------------------------------------------------------
  // interrupt levels of the cascaded controller
  // ----------------------------------------------------------------
  localparam logic [3:0]  LVL_KBD      = 4'hF;
  localparam logic [3:0]  LVL_TIMER    = 4'hE;
  localparam logic [3:0]  LVL_IPC      = 4'hD;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 20;
  localparam int START_PULSE_NS   = 2000;
  localparam int START_PULSE_CYC  =
    (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALT_TIMEOUT_MS  = 100;
  localparam int HALT_TIMEOUT_CYC =
    (HALT_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TMO_W            = 23;

  typedef enum logic [1:0] {
    MC_RUN    = 2'b01,
    MC_HALTED = 2'b10
  } mc_halt_t;

endpackage : mc_pkg
`default_nettype wire

// ### test_sampler_master_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_sampler_master_control;
  logic clock;
  logic nrst = 1'b0, bus_strobe = 1'b0, bus_read = 1'b0, bus_cpu_one = 1'b0;
  logic keyboard_serial_irq = 1'b0, timer_irq = 1'b0, ipc_irq = 1'b0;
  logic converter_mode = 1'b0, sample_clock = 1'b0, conversion_done_n;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00, answer_delay = 8'h05;
  logic [9:0]  converter_data, result = 10'h2B6;
  logic [7:0]  bus_rdata, channel_card_select, tuning_word, atten_word;
  logic [3:0]  irq_level_bus, lowpass_sel, highpass_sel;
  logic card_select, pitch_ref, wave_refresh, wave_row_addr_sel;
  logic wave_row_strobe, wave_col_strobe, pic_int_n, cpu_one_irq_request;
  logic conv_start, sample_hold, cpu_hold_n;
  int err_total = 0;
  int total_checks = 0;
  logic [15:0] row_addr [5] = '{mc_pkg::TUNE_ADDR, mc_pkg::ATTEN_ADDR,
    mc_pkg::FILTER_ADDR, mc_pkg::FILTER_ADDR, mc_pkg::TUNE_ADDR};
  logic [7:0] row_data [5] = '{8'h3C, 8'hA7, 8'h5E, 8'hE5, 8'hFF};
  logic [3:0] lvl_tab [3] = '{mc_pkg::LVL_KBD, mc_pkg::LVL_TIMER,
    mc_pkg::LVL_IPC};

  mc_master #(.HALT_TIMEOUT_CYC(200)) dut (
    .clock, .nrst, .bus_strobe, .bus_read, .bus_cpu_one, .bus_addr,
    .bus_wdata, .bus_rdata, .card_select, .channel_card_select,
    .tuning_word, .pitch_ref, .wave_refresh, .wave_row_addr_sel,
    .wave_row_strobe, .wave_col_strobe, .keyboard_serial_irq, .timer_irq,
    .ipc_irq, .pic_int_n, .cpu_one_irq_request, .irq_level_bus,
    .converter_mode, .sample_clock, .conversion_done_n, .converter_data,
    .conv_start, .sample_hold, .cpu_hold_n, .atten_word, .lowpass_sel,
    .highpass_sel
  );

  mc_conv_model conv (
    .clock, .nrst, .conv_start, .answer_delay, .result,
    .conversion_done_n, .converter_data
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  task automatic expire(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      $display("[FAIL] t=%0t wait ran out n=%h lim=%h", $time, n, lim);
      tally_and_finish();
    end
  endtask : expire

  // one access; returns just after the edge that registers the answer
  task automatic bus_op(input logic rd, input logic one,
                        input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_strobe  <= 1'b1;
    bus_read    <= rd;
    bus_cpu_one <= one;
    bus_addr    <= a;
    bus_wdata   <= d;
    @(posedge clock);
    bus_strobe <= 1'b0;
    #1;
  endtask : bus_op

  function automatic logic [7:0] out_for(input logic [15:0] a);
    case (a)
      mc_pkg::TUNE_ADDR:  out_for = tuning_word;
      mc_pkg::ATTEN_ADDR: out_for = atten_word;
      default:            out_for = {highpass_sel, lowpass_sel};
    endcase
  endfunction : out_for

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    int w;
    logic prev;
    logic [3:0] wv;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    check_byte(tuning_word, mc_pkg::TUNE_RST);
    check_bit(cpu_hold_n, 1'b1);
    check_bit(cpu_one_irq_request, 1'b0);
    bus_op(1'b0, 1'b0, 16'hE005, 8'h11);
    check_byte(channel_card_select, 8'h00);
    for (int i = 0; i < 5; i++) begin
      bus_op(1'b0, 1'b0, row_addr[i], row_data[i]);
      check_byte(out_for(row_addr[i]), row_data[i]);
    end
    bus_op(1'b1, 1'b0, mc_pkg::TUNE_ADDR, 8'h00);
    check_byte(bus_rdata, 8'hFF);
    bus_op(1'b0, 1'b0, mc_pkg::MASK_ADDR, 8'h05);
    bus_op(1'b0, 1'b0, 16'hE005, 8'h00);
    check_bit(card_select, 1'b1);
    check_byte(channel_card_select, 8'h05);
    bus_op(1'b1, 1'b0, 16'hE01F, 8'h00);
    check_byte(channel_card_select, 8'h00);
    bus_op(1'b0, 1'b0, mc_pkg::MASK_ADDR, 8'h80);
    bus_op(1'b1, 1'b0, 16'hE01F, 8'h00);
    check_byte(channel_card_select, 8'h80);
    bus_op(1'b0, 1'b0, 16'hE03F, 8'h00);
    check_bit(card_select, 1'b1);
    check_byte(channel_card_select, 8'h00);
    bus_op(1'b1, 1'b0, 16'hE03A, 8'h00);
    check_byte(bus_rdata, 8'h00);
    bus_op(1'b0, 1'b0, 16'hE040, 8'h00);
    check_bit(card_select, 1'b0);
    bus_op(1'b1, 1'b0, mc_pkg::MASK_ADDR, 8'h00);
    check_byte(bus_rdata, 8'h80);
    n = 0;
    w = 0;
    prev = pitch_ref;
    wv = {wave_refresh, wave_row_addr_sel, wave_row_strobe, wave_col_strobe};
    repeat (64) begin
      @(posedge clock);
      #1;
      if (pitch_ref !== prev) n++;
      if ({wave_refresh, wave_row_addr_sel, wave_row_strobe,
           wave_col_strobe} !== wv) w++;
      prev = pitch_ref;
    end
    check_bit(n > 0, 1'b1);
    check_bit(w > 0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      {keyboard_serial_irq, timer_irq, ipc_irq} <= 3'b100 >> i;
      n = 0;
      while (pic_int_n !== 1'b0 && n < 10) begin
        @(posedge clock);
        #1;
        n++;
      end
      expire(n, 10);
      check_byte({4'h0, irq_level_bus}, {4'h0, lvl_tab[i]});
      @(posedge clock);
      #1;
      check_bit(cpu_one_irq_request, 1'b1);
      @(posedge clock);
      {keyboard_serial_irq, timer_irq, ipc_irq} <= 3'b000;
      repeat (4) @(posedge clock);
    end
    repeat (2) bus_op(1'b0, 1'b1, mc_pkg::PRIO_ADDR, 8'h0F);
    repeat (2) @(posedge clock);
    #1;
    check_bit(cpu_one_irq_request, 1'b0);
    @(posedge clock);
    keyboard_serial_irq <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check_bit(pic_int_n, 1'b1);
    @(posedge clock);
    keyboard_serial_irq <= 1'b0;
    bus_op(1'b0, 1'b0, mc_pkg::HALT_ADDR, 8'h00);
    check_bit(cpu_hold_n, 1'b1);
    bus_op(1'b1, 1'b1, mc_pkg::HALT_ADDR, 8'h00);
    check_bit(cpu_hold_n, 1'b0);
    @(posedge clock);
    sample_clock <= 1'b1;
    n = 0;
    while (conv_start !== 1'b1 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    expire(n, 8);
    n = 0;
    prev = conversion_done_n;
    while (conv_start === 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
      check_bit(sample_hold, prev);
      prev = conversion_done_n;
    end
    check_byte(8'(n), 8'(mc_pkg::START_PULSE_CYC));
    check_bit(cpu_hold_n, 1'b1);
    bus_op(1'b1, 1'b0, mc_pkg::ADC_LO_ADDR, 8'h00);
    check_byte(bus_rdata, result[7:0]);
    bus_op(1'b1, 1'b0, mc_pkg::ADC_HI_ADDR, 8'h00);
    check_byte({6'h00, bus_rdata[1:0]}, {6'h00, result[9:8]});
    @(posedge clock);
    sample_clock <= 1'b0;
    converter_mode <= 1'b1;
    @(posedge clock);
    sample_clock <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check_bit(conv_start, 1'b0);
    bus_op(1'b0, 1'b1, mc_pkg::HALT_ADDR, 8'h00);
    repeat (150) @(posedge clock);
    #1;
    check_bit(cpu_hold_n, 1'b0);
    n = 0;
    while (cpu_hold_n !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    expire(n, 100);
    check_byte(8'(n), 8'h32);
    check_bit(cpu_hold_n, 1'b1);
    tally_and_finish();
  end
endmodule : test_sampler_master_control
`default_nettype wire
